// file: src/lag_consts.svh
`ifndef LAG_CONSTS_SVH
`define LAG_CONSTS_SVH
`define CNT_W 10
`define CNT_MAX 10'h3FF
`define PER_W 12
`define THR_W 10
`define DEB_W 8
`define MODE_TIMER_BIT 1
`define CLK_SYSDIV 3'h0
`define CLK_SYSDIV4 3'h1
`define CLK_HIGH 3'h2
`define CLK_SLOW 3'h3
`define CLK_EVENT_RISE 3'h4
`define CLK_EVENT_FALL 3'h5
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_BOTH 2'h2
`define WAIT_BASE_W 16
`endif

// file: src/lag_pkg.sv
package lag_pkg;
    typedef struct packed {
        logic [1:0] counter_mode_sel;
        logic [2:0] counter_clk_sel;
        logic [2:0] wait_time_sel;
        logic [1:0] capture_edge_sel;
        logic event_source_sel;
    } counter_cfg_type;
    typedef struct packed {
        logic overflow_flag;
        logic capture_flag;
        logic ceiling_violation_flag;
        logic short_lag_flag;
        logic no_lag_flag;
    } flags_type;
    typedef enum logic [1:0] {
        PD_IDLE = 2'b00,
        PD_LAG = 2'b01,
        PD_DONE = 2'b11
    } pd_state_type;
endpackage

// file: src/cmp_debounce.sv
`timescale 1ns/1ns
`default_nettype none
`include "lag_consts.svh"
module cmp_debounce (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // comparator pin and setting
    input wire logic raw_in,
    input wire logic [`DEB_W-1:0] deb_time,
    // filtered level
    output logic clean_out
);
    logic s1_q, s1_d, s2_q, s2_d, out_q, out_d;
    logic [`DEB_W-1:0] cnt_q, cnt_d;
    // two flops first: comparator is asynchronous to core_clk
    always_comb begin
        s1_d = raw_in;
        s2_d = s1_q;
        out_d = out_q;
        cnt_d = '0;
        if (s2_q != out_q) begin
            cnt_d = cnt_q + `DEB_W'(1);
            if (cnt_q >= deb_time) begin
                out_d = s2_q;
                cnt_d = '0;
            end
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            out_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            out_q <= out_d;
            cnt_q <= cnt_d;
        end
    end
    assign clean_out = out_q;
endmodule
`default_nettype wire

// file: src/lag_detect.sv
`timescale 1ns/1ns
`default_nettype none
`include "lag_consts.svh"
module lag_detect
    import lag_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // drive and current levels, already synchronous
    input wire logic drive_in,
    input wire logic current_in,
    input wire logic [`THR_W-1:0] min_lag_threshold,
    // lag output and one-cycle fault events
    output logic lag_pulse,
    output logic short_evt,
    output logic none_evt
);
    pd_state_type st_q, st_d;
    logic drv_q, drv_d;
    logic [`THR_W-1:0] w_q, w_d;
    logic lag, lag_q, lag_d;
    // a pulse opens only at the drive rising edge: a current that leads
    // and falls early gives no width
    assign lag = drive_in & ~current_in & (lag_q | ~drv_q);
    always_comb begin
        drv_d = drive_in;
        lag_d = lag;
        st_d = st_q;
        w_d = w_q;
        short_evt = 1'b0;
        none_evt = 1'b0;
        case (st_q)
            PD_IDLE: begin
                if (lag) begin
                    st_d = PD_LAG;
                    w_d = `THR_W'(1);
                end
            end
            PD_LAG: begin
                if (lag) begin
                    if (w_q != '1) begin
                        w_d = w_q + `THR_W'(1);
                    end
                end else begin
                    st_d = PD_DONE;
                    short_evt = (w_q < min_lag_threshold);
                end
            end
            PD_DONE: st_d = PD_DONE; // later pulses ignored
            default: st_d = PD_IDLE;
        endcase
        // detection period ends at the drive falling edge
        if (drv_q & ~drive_in) begin
            // current already low at the drive fall: drive lagged, no width
            none_evt = (st_q == PD_IDLE) & ~current_in;
            st_d = PD_IDLE;
            w_d = '0;
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= PD_IDLE;
            drv_q <= 1'b0;
            lag_q <= 1'b0;
            w_q <= '0;
        end else begin
            st_q <= st_d;
            drv_q <= drv_d;
            lag_q <= lag_d;
            w_q <= w_d;
        end
    end
    assign lag_pulse = lag_q;
endmodule
`default_nettype wire

// file: src/phase_lag_capture_counter.sv
// Overview of operation
// - detector 0 pairs drive 0 with current 0, detector 1 pairs the 1s.
// - current lagging drive yields a lag pulse as wide as the lag.
// - no phase difference keeps the lag pulse low.
// - drive lagging current gives no width and triggers protection.
// - both comparator outputs are debounced with programmable time.
// - 10-bit up-counter clocked from divided system, high, slow or event clock.
// - only a rising run bit clears counter; capture is read-only.
// - mode 10 or 11 is timer/counter, counting 0 to 1023.
// - reaching 1023 in timer mode sets the overflow flag.
// - wait time elapsed latches count, sets capture flag, clears run.
// - event clock counts on its rising or falling edge, selectable.
// - mode 00 or 01 is capture mode with rising, falling or both edges.
// - run rising starts counting; each chosen edge latches and flags.
// - capture mode counter free-runs until the run bit falls.
// - event clock comes from comparator 0 or 1 by one select bit.
// - with ceiling enabled, periods above ceiling are dropped and flagged.
// - lag narrower than the minimum threshold sets short-lag flag.
// - zero lag width sets the no-lag flag.
// - either lag fault raises protect event, and fault guard if routed.
// - lag flags set by hardware only, cleared by software.
// - only the first lag pulse of each detection period is measured.
// - no-lag with its own comparator still high at the drive fall sets neither flag nor event.
`timescale 1ns/1ns
`default_nettype none
`include "lag_consts.svh"
module phase_lag_capture_counter
    import lag_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // drive and comparator pins
    input wire logic drive_out_0,
    input wire logic drive_out_1,
    input wire logic current_comparator_0,
    input wire logic current_comparator_1,
    // clock enable for the high-speed source, falling-edge clock for the slow source
    input wire logic high_speed_clock,
    input wire logic slow_clock,
    // configuration
    input wire counter_cfg_type cfg,
    input wire logic [`DEB_W-1:0] debounce_time,
    input wire logic [`THR_W-1:0] min_lag_threshold,
    input wire logic capture_src_sel,
    input wire logic fault_route_en0,
    // run control: set level and software clear pulse
    input wire logic run_set,
    input wire logic run_clr,
    // period write with ceiling check
    input wire logic ceiling_enable,
    input wire logic [`PER_W-1:0] period_ceiling,
    input wire logic period_wr,
    input wire logic [`PER_W-1:0] period_wdata,
    // flag clears, one bit per flag
    input wire flags_type flag_clr,
    // status
    output logic counter_run,
    output logic [`CNT_W-1:0] lag_counter,
    output logic [`CNT_W-1:0] capture_value,
    output logic [`PER_W-1:0] period_value,
    output flags_type flags,
    output logic lag_pulse_0,
    output logic lag_pulse_1,
    output logic lag_protect_event,
    output logic fault_guard
);
    // ************************************************
    // comparator conditioning
    // ************************************************
    logic current_cmp0_out, current_cmp1_out;
    logic sh_q, sh_d, ss_q, ss_d, hs_q, hs_d, sl_q, sl_d, sp_q, sp_d;
    logic dr0_s_q, dr0_s_d, dr0_m_q, dr0_m_d, dr0_q, dr0_d;
    logic dr1_s_q, dr1_s_d, dr1_m_q, dr1_m_d, dr1_q, dr1_d;
    logic sh0_evt, sh1_evt, no0_evt, no1_evt;
    cmp_debounce u_deb0 (
        .core_clk(core_clk),
        .rst(rst),
        .raw_in(current_comparator_0),
        .deb_time(debounce_time),
        .clean_out(current_cmp0_out)
    );
    cmp_debounce u_deb1 (
        .core_clk(core_clk),
        .rst(rst),
        .raw_in(current_comparator_1),
        .deb_time(debounce_time),
        .clean_out(current_cmp1_out)
    );
    // ************************************************
    // drive synchronisers
    // ************************************************
    // third stage matches the debounce register, so equal phases stay
    // equal and give no lag pulse
    always_comb begin
        dr0_s_d = drive_out_0;
        dr1_s_d = drive_out_1;
        dr0_m_d = dr0_s_q;
        dr1_m_d = dr1_s_q;
        dr0_d = dr0_m_q;
        dr1_d = dr1_m_q;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dr0_s_q <= 1'b0;
            dr1_s_q <= 1'b0;
            dr0_m_q <= 1'b0;
            dr1_m_q <= 1'b0;
            dr0_q <= 1'b0;
            dr1_q <= 1'b0;
        end else begin
            dr0_s_q <= dr0_s_d;
            dr1_s_q <= dr1_s_d;
            dr0_m_q <= dr0_m_d;
            dr1_m_q <= dr1_m_d;
            dr0_q <= dr0_d;
            dr1_q <= dr1_d;
        end
    end
    lag_detect u_pd0 (
        .core_clk(core_clk),
        .rst(rst),
        .drive_in(dr0_q),
        .current_in(current_cmp0_out),
        .min_lag_threshold(min_lag_threshold),
        .lag_pulse(lag_pulse_0),
        .short_evt(sh0_evt),
        .none_evt(no0_evt)
    );
    lag_detect u_pd1 (
        .core_clk(core_clk),
        .rst(rst),
        .drive_in(dr1_q),
        .current_in(current_cmp1_out),
        .min_lag_threshold(min_lag_threshold),
        .lag_pulse(lag_pulse_1),
        .short_evt(sh1_evt),
        .none_evt(no1_evt)
    );
    // ************************************************
    // counter clock selection
    // ************************************************
    logic event_clock, ev_q, ev_d, cap_sig, cap_q, cap_d;
    logic [1:0] div_q, div_d;
    logic cnt_tick, cap_edge;
    assign event_clock = cfg.event_source_sel ? current_cmp1_out
                                              : current_cmp0_out;
    assign cap_sig = capture_src_sel ? lag_pulse_1 : lag_pulse_0;
    function automatic logic edge_pick(
        input logic now_v,
        input logic was_v,
        input logic [1:0] sel
    );
        case (sel)
            `EDGE_RISE: edge_pick = now_v & ~was_v;
            `EDGE_FALL: edge_pick = ~now_v & was_v;
            default: edge_pick = now_v ^ was_v;
        endcase
    endfunction
    // slow edge taken past the second stage; the first flop feeds only it
    always_comb begin
        div_d = div_q + 2'h1;
        ev_d = event_clock;
        cap_d = cap_sig;
        sh_d = high_speed_clock;
        hs_d = sh_q;
        ss_d = slow_clock;
        sl_d = ss_q;
        sp_d = sl_q;
        case (cfg.counter_clk_sel)
            `CLK_SYSDIV: cnt_tick = 1'b1;
            `CLK_SYSDIV4: cnt_tick = (div_q == 2'h3);
            `CLK_HIGH: cnt_tick = hs_q;
            `CLK_SLOW: cnt_tick = edge_pick(sl_q, sp_q, `EDGE_FALL);
            `CLK_EVENT_RISE: begin
                cnt_tick = edge_pick(event_clock, ev_q, `EDGE_RISE);
            end
            `CLK_EVENT_FALL: begin
                cnt_tick = edge_pick(event_clock, ev_q, `EDGE_FALL);
            end
            // selects 6 and 7 leave the counter idle
            default: cnt_tick = 1'b0;
        endcase
        cap_edge = edge_pick(cap_sig, cap_q, cfg.capture_edge_sel);
    end
    // ************************************************
    // counter, wait timer and capture
    // ************************************************
    logic run_q, run_d, runp_q, runp_d;
    logic [`CNT_W-1:0] cnt_q, cnt_d, capv_q, capv_d;
    logic [`WAIT_BASE_W-1:0] wt_q, wt_d;
    logic timer_mode, wait_done, run_rise;
    flags_type fl_q, fl_d;
    logic [`PER_W-1:0] per_q, per_d;
    // wait time doubles per step; base is a cycle count that runs only while run is set in timer mode
    function automatic logic [`WAIT_BASE_W-1:0] wait_len(
        input logic [2:0] sel
    );
        wait_len = `WAIT_BASE_W'(16'h0100 << sel);
    endfunction
    assign timer_mode = cfg.counter_mode_sel[`MODE_TIMER_BIT];
    assign run_rise = run_q & ~runp_q;
    assign wait_done = timer_mode & run_q & ~run_rise
                       & (wt_q == wait_len(cfg.wait_time_sel) - 16'h1);
    always_comb begin
        run_d = run_q;
        runp_d = run_q;
        cnt_d = cnt_q;
        capv_d = capv_q; // no write path into the capture value
        wt_d = wt_q;
        per_d = per_q;
        fl_d = fl_q & ~flag_clr; // clear first, hardware set below
        if (run_set) begin
            run_d = 1'b1;
        end
        // a clear in the same cycle as a set wins
        if (run_clr) begin
            run_d = 1'b0; // stops counting
        end
        if (run_rise) begin
            cnt_d = '0; // sole software effect on the counter
            wt_d = '0;
        end else if (run_q) begin
            if (cnt_tick) begin
                cnt_d = cnt_q + `CNT_W'(1); // wraps 1023 to 0
                if (timer_mode && cnt_q == `CNT_MAX - `CNT_W'(1)) begin
                    fl_d.overflow_flag = 1'b1;
                end
            end
            if (timer_mode) begin
                wt_d = wt_q + `WAIT_BASE_W'(1);
            end
        end
        if (wait_done) begin
            capv_d = cnt_q;
            fl_d.capture_flag = 1'b1;
            run_d = 1'b0;
        end
        // the run-rise cycle still holds the old count, so no capture then
        if (!timer_mode && run_q && !run_rise && cap_edge) begin
            capv_d = cnt_q;
            fl_d.capture_flag = 1'b1;
        end
        if (period_wr) begin
            if (ceiling_enable && period_wdata > period_ceiling) begin
                fl_d.ceiling_violation_flag = 1'b1; // write dropped
            end else begin
                per_d = period_wdata;
            end
        end
        if (sh0_evt | sh1_evt) begin
            fl_d.short_lag_flag = 1'b1;
        end
        if (no0_evt | no1_evt) begin
            fl_d.no_lag_flag = 1'b1;
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
            runp_q <= 1'b0;
            cnt_q <= '0;
            capv_q <= '0;
            wt_q <= '0;
            per_q <= '0;
            fl_q <= '0;
            div_q <= '0;
            ev_q <= 1'b0;
            cap_q <= 1'b0;
            sh_q <= 1'b0;
            hs_q <= 1'b0;
            ss_q <= 1'b0;
            sl_q <= 1'b0;
            sp_q <= 1'b0;
        end else begin
            run_q <= run_d;
            runp_q <= runp_d;
            cnt_q <= cnt_d;
            capv_q <= capv_d;
            wt_q <= wt_d;
            per_q <= per_d;
            fl_q <= fl_d;
            div_q <= div_d;
            ev_q <= ev_d;
            cap_q <= cap_d;
            sh_q <= sh_d;
            hs_q <= hs_d;
            ss_q <= ss_d;
            sl_q <= sl_d;
            sp_q <= sp_d;
        end
    end
    // ************************************************
    // outputs
    // ************************************************
    assign counter_run = run_q;
    assign lag_counter = cnt_q;
    assign capture_value = capv_q;
    assign period_value = per_q;
    assign flags = fl_q;
    // level while either lag flag stands
    assign lag_protect_event = fl_q.short_lag_flag | fl_q.no_lag_flag;
    assign fault_guard = lag_protect_event & fault_route_en0;
endmodule
`default_nettype wire

// file: verification/lag_counter_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "lag_consts.svh"
module lag_counter_monitor
    import lag_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // controls
    input wire counter_cfg_type cfg,
    input wire logic fault_route_en0,
    input wire logic run_clr,
    input wire logic ceiling_enable,
    input wire logic [`PER_W-1:0] period_ceiling,
    input wire logic period_wr,
    input wire logic [`PER_W-1:0] period_wdata,
    input wire flags_type flag_clr,
    // status
    input wire logic counter_run,
    input wire logic [`CNT_W-1:0] lag_counter,
    input wire logic [`CNT_W-1:0] capture_value,
    input wire logic [`PER_W-1:0] period_value,
    input wire flags_type flags,
    input wire logic lag_protect_event,
    input wire logic fault_guard
);
    // ****************
    // port properties
    // ****************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    property p_guard;
        fault_guard == (lag_protect_event && fault_route_en0);
    endproperty
    a_guard: assert property (p_guard) else $error("guard mismatch");
    property p_protect;
        lag_protect_event == (flags.short_lag_flag || flags.no_lag_flag);
    endproperty
    a_protect: assert property (p_protect) else $error("protect bad");
    property p_sticky;
        flags.ceiling_violation_flag && !flag_clr.ceiling_violation_flag
            |=> flags.ceiling_violation_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");
    property p_cap_change;
        $changed(capture_value) |-> ##[0:1] flags.capture_flag;
    endproperty
    a_cap_change: assert property (p_cap_change) else $error("cap");
    property p_run_clear;
        $rose(counter_run) |=> lag_counter == '0;
    endproperty
    a_run_clear: assert property (p_run_clear) else $error("no clear");
    property p_refuse;
        period_wr && ceiling_enable && period_wdata > period_ceiling
            |=> $stable(period_value) && flags.ceiling_violation_flag;
    endproperty
    a_refuse: assert property (p_refuse) else $error("over ceiling");
    property p_store;
        period_wr && !(ceiling_enable && period_wdata > period_ceiling)
            |=> period_value == $past(period_wdata);
    endproperty
    a_store: assert property (p_store) else $error("period lost");
    property p_timer_wait;
        $fell(counter_run) && cfg.counter_mode_sel[1] && !$past(run_clr)
            |-> ##[0:1] flags.capture_flag;
    endproperty
    a_timer_wait: assert property (p_timer_wait) else $error("wait");
endmodule
bind phase_lag_capture_counter lag_counter_monitor lag_counter_monitor_i (
    .core_clk(core_clk), .rst(rst), .cfg(cfg),
    .fault_route_en0(fault_route_en0), .run_clr(run_clr),
    .ceiling_enable(ceiling_enable), .period_ceiling(period_ceiling),
    .period_wr(period_wr), .period_wdata(period_wdata),
    .flag_clr(flag_clr), .counter_run(counter_run),
    .lag_counter(lag_counter), .capture_value(capture_value),
    .period_value(period_value), .flags(flags),
    .lag_protect_event(lag_protect_event), .fault_guard(fault_guard)
);
`default_nettype wire

// file: verification/resonant_model.sv
`timescale 1ns/1ns
`default_nettype none
module resonant_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // waveform shape; negative lag means current leads
    input wire logic [7:0] half_per,
    input wire logic signed [7:0] lag,
    input wire logic hold_high,
    // pins toward the block
    output logic drive_0,
    output logic drive_1,
    output logic cur_0,
    output logic cur_1
);
    // ****************
    // waveforms
    // ****************
    int cnt;
    int ph;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
        end else begin
            cnt <= (cnt + 1) % (2 * int'(half_per));
        end
    end
    // complementary legs, no dead time: the block never sees it
    always_comb begin
        ph = (cnt - int'(lag) + 2 * int'(half_per)) % (2 * int'(half_per));
        drive_0 = cnt < int'(half_per);
        drive_1 = !drive_0;
        cur_0 = hold_high || ph < int'(half_per);
        cur_1 = hold_high || !(ph < int'(half_per));
    end
endmodule
`default_nettype wire

// file: verification/phase_lag_capture_counter_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "lag_consts.svh"
module phase_lag_capture_counter_tb
    import lag_pkg::*;
;
    // ****************
    // signals
    // ****************
    logic core_clk, rst, hs_clk, slow_clk, route_en, run_set, run_clr;
    logic ceil_en, period_wr, src_sel, hold, d0, d1, c0, c1, run, prot, guard;
    logic [7:0] deb, half;
    logic signed [7:0] lag;
    logic [`THR_W-1:0] thr;
    logic [`PER_W-1:0] ceil, pwd, per;
    logic [`CNT_W-1:0] cnt, cap, a, b, d;
    counter_cfg_type cfg;
    flags_type flag_clr, flags;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    logic lp0, lp1;
    int n0, n1;
    int etab[6] = '{255, 63, 255, 16, 8, 8};
    logic [11:0] wtab[4] = '{12'h1FF, 12'h201, 12'h200, 12'hFFF};
    logic [11:0] ptab[4] = '{12'h1FF, 12'h1FF, 12'h200, 12'hFFF};
    phase_lag_capture_counter phase_lag_capture_counter_i (
        .core_clk(core_clk), .rst(rst), .drive_out_0(d0), .drive_out_1(d1),
        .current_comparator_0(c0), .current_comparator_1(c1),
        .high_speed_clock(hs_clk), .slow_clock(slow_clk), .cfg(cfg),
        .debounce_time(deb), .min_lag_threshold(thr),
        .capture_src_sel(src_sel), .fault_route_en0(route_en),
        .run_set(run_set), .run_clr(run_clr), .ceiling_enable(ceil_en),
        .period_ceiling(ceil), .period_wr(period_wr), .period_wdata(pwd),
        .flag_clr(flag_clr), .counter_run(run), .lag_counter(cnt),
        .capture_value(cap), .period_value(per), .flags(flags),
        .lag_pulse_0(lp0), .lag_pulse_1(lp1), .lag_protect_event(prot),
        .fault_guard(guard)
    );
    resonant_model resonant_model_i (
        .core_clk(core_clk), .rst(rst), .half_per(half), .lag(lag),
        .hold_high(hold), .drive_0(d0), .drive_1(d1), .cur_0(c0), .cur_1(c1)
    );
    // ****************
    // clock, timeout, tasks
    // ****************
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // slow source falls every 16 cycles; hang guard well above run length
    always @(posedge core_clk) begin
        slow_clk <= (cyc % 16) < 8;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    task automatic close_out();
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic run_pulse(input logic clr);
        @(posedge core_clk);
        run_clr <= clr;
        run_set <= !clr;
        @(posedge core_clk);
        run_clr <= 1'b0;
        run_set <= 1'b0;
    endtask
    task automatic clear(input logic [4:0] m);
        @(posedge core_clk);
        flag_clr <= flags_type'(m);
        @(posedge core_clk);
        flag_clr <= '0;
    endtask
    // capture flag set, or run dropped, bounded
    task automatic wait_on(input logic capt);
        int i;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (i < 5000 && (capt ? flags.capture_flag !== 1'b1
                                     : run !== 1'b0));
    endtask
    task automatic write_period(input logic en, input logic [11:0] v);
        @(posedge core_clk);
        ceil_en <= en;
        pwd <= v;
        period_wr <= 1'b1;
        @(posedge core_clk);
        period_wr <= 1'b0;
        tick(1);
    endtask
    // ****************
    // tests
    // ****************
    initial begin
        {rst, hs_clk} = 2'b11;
        {slow_clk, route_en, run_set, run_clr, ceil_en, period_wr} = '0;
        {src_sel, hold, deb, thr, ceil, pwd, cfg, flag_clr} = '0;
        half = 8'd20;
        lag = 8'sd8;
        tick(8);
        check({flags, run, cap, per}, 28'h0);
        rst <= 1'b0;
        ceil <= 12'h200;
        for (int i = 0; i < 4; i++) begin
            write_period(i != 3, wtab[i]);
            check(per, ptab[i]);
        end
        check(flags.ceiling_violation_flag, 1'b1);
        clear(5'h04);
        tick(1);
        check(flags.ceiling_violation_flag, 1'b0);
        half <= 8'd16;
        for (int i = 0; i < 6; i++) begin
            cfg <= '{2'b10, 3'(i), 3'h0, 2'h0, 1'(i / 5)};
            run_pulse(1'b0);
            wait_on(1'b0);
            check(flags.capture_flag, 1'b1);
            check(cap + 3 >= etab[i] && cap <= etab[i] + 3, 1);
            clear(5'h08);
        end
        cfg <= '{2'b11, 3'h0, 3'h3, 2'h0, 1'b0};
        run_pulse(1'b0);
        wait_on(1'b0);
        check(flags[4:3], 2'b11);
        clear(5'h18);
        cfg <= '{2'b10, 3'h0, 3'h7, 2'h0, 1'b0};
        run_pulse(1'b0);
        tick(50);
        check(cnt >= 10'd44 && cnt <= 10'd50, 1);
        run_pulse(1'b1);
        tick(2);
        check({run, flags.capture_flag}, 2'b00);
        half <= 8'd20;
        for (int i = 0; i < 6; i++) begin
            cfg <= '{2'(i % 2), 3'h0, 3'h0, 2'(i / 2), 1'b0};
            src_sel <= 1'(i % 2);
            run_pulse(1'b0);
            clear(5'h08);
            wait_on(1'b1);
            a = cap;
            clear(5'h08);
            wait_on(1'b1);
            b = cap;
            d = b - a;
            if (i < 4) begin
                check(d, 10'd40);
            end else begin
                check((d >= 7 && d <= 10) || (d >= 30 && d <= 33), 1);
            end
            run_pulse(1'b1);
            clear(5'h08);
        end
        thr <= 10'h00A;
        lag <= 8'sd4;
        route_en <= 1'b1;
        tick(150);
        check({flags.short_lag_flag, prot, guard}, 3'b111);
        route_en <= 1'b0;
        tick(2);
        check(guard, 1'b0);
        thr <= 10'h002;
        lag <= 8'sd8;
        tick(50);
        clear(5'h1F);
        tick(150);
        check(flags[1:0], 2'b00);
        lag <= -8'sd2;
        tick(150);
        check({flags.no_lag_flag, prot}, 2'b11);
        hold <= 1'b1;
        tick(50);
        clear(5'h1F);
        tick(150);
        check(flags.no_lag_flag, 1'b0);
        hold <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            lag <= 8'(8 - 8 * k);
            tick(50);
            n0 = 0;
            n1 = 0;
            repeat (80) begin
                tick(1);
                n0 += lp0;
                n1 += lp1;
            end
            check(n0, 16 - 16 * k);
            check(n1, 16 - 16 * k);
        end
        close_out();
    end
endmodule
`default_nettype wire
